// File: src/scm_map.sv
// Cyclic command interpreter and status assembler for a motor soft starter
// Functional notes
// - Accept control only from output instance 104, class 0x04
// - All assembly fields are least significant byte first
// - Run bit one issues start command
// - Run bit zero issues stop command
// - Trip reset only on reset bit rising
// - Byte 1 bit 5 picks parameter bank
// - Status served only through input instance 154
// - Bytes 0-1 status; 2-3, 10-11 zero
// - Bytes 4-7 carry current in 0.01 A
// - Bytes 8-9 carry fault cause code
// - Status bit 0 shows command acceptance
// - Bit 1 network authority, bit 9 remote
// - Status bit 8 shows full voltage
// - Status bit 11 shows starter active
// - Status bit 15 shows motor overtemperature
// - Keep control word; forward only changed commands
// - Exchanges spaced no less than one millisecond
`timescale 1ns/100ps

module scm_map #(
  parameter int GAP_CYCLES = scm_pkg::MIN_GAP_CYC   // Least cycles between accepted exchanges
) (
  input  wire logic                    CLK_I,         // System clock, 50 MHz
  input  wire logic                    RST_I,         // Synchronous reset, active high
  input  wire scm_pkg::scm_out_frame_t OUT_FRAME_I,   // Cyclic output frame
  output logic                         OUT_ACCEPT_O,  // Frame taken, pulse
  output logic                         OUT_REJECT_O,  // Frame refused, pulse
  input  wire logic                    IN_REQ_I,      // Input assembly request, pulse
  input  wire logic [7:0]              IN_CLASS_I,    // Requested class
  input  wire logic [7:0]              IN_INST_I,     // Requested instance
  output logic                         IN_VALID_O,    // Input assembly ready, pulse
  output logic                         IN_REJECT_O,   // Request refused, pulse
  output logic [95:0]                  IN_DATA_O,     // Input bytes 0..11, byte 0 lowest
  input  wire scm_pkg::scm_starter_t   STARTER_I,     // Starter state
  output logic                         CMD_START_O,   // Start command, pulse
  output logic                         CMD_STOP_O,    // Stop command, pulse
  output logic                         CMD_RESET_O,   // Trip reset command, pulse
  output logic                         BANK_SEL_O     // Parameter bank for next start
);

  // Whole state of the block
  typedef struct packed {
    logic [15:0] cmd_word;    // Last accepted control word
    logic        fwd_valid;   // A run command has been forwarded
    logic        fwd_run;     // Last forwarded run value
    logic [15:0] out_gap;     // Cycles since last accepted output frame
    logic [15:0] in_gap;      // Cycles since last served input request
    logic        out_accept;  // Output strobes, input assembly data and bank select
    logic        out_reject;
    logic        in_valid;
    logic        in_reject;
    logic [95:0] in_data;
    logic        start;
    logic        stop;
    logic        trip_reset;
    logic        bank;
  } scm_state_t;

  scm_state_t state_reg;    // Registered state
  scm_state_t state_next;   // Next state

  localparam logic [15:0] GAP_LIMIT = 16'(GAP_CYCLES - 1);  // Counter value that allows the next exchange

  // Saturating count of cycles since last exchange
  function automatic logic [15:0] gap_step(input logic [15:0] cnt, input logic taken);
    if (taken) begin
      gap_step = 16'h0000;
    end else if (cnt == 16'hFFFF) begin
      gap_step = cnt;
    end else begin
      gap_step = cnt + 16'h0001;
    end
  endfunction

  // Builds the 16-bit status word from the starter state
  function automatic logic [15:0] status_word(input scm_pkg::scm_starter_t st);
    status_word = 16'h0000;
    status_word[scm_pkg::ST_READY_POS]  = st.ready;
    status_word[scm_pkg::ST_NET_POS]    = st.net_ctrl;
    status_word[scm_pkg::ST_REMOTE_POS] = st.remote;
    status_word[scm_pkg::ST_ENABLE_POS] = st.enabled;
    status_word[scm_pkg::ST_TRIP_POS]   = st.tripped;
    status_word[scm_pkg::ST_WARN_POS]   = st.warning;
    status_word[scm_pkg::ST_FULLV_POS]  = st.full_volts;
    status_word[scm_pkg::ST_ON_POS]     = st.active;
    status_word[scm_pkg::ST_HOT_POS]    = st.overtemp;
  endfunction

  logic out_addr_ok;   // Frame addressed to the one valid output instance
  logic out_take;      // Frame accepted this cycle
  logic in_addr_ok;    // Request addressed to the one valid input instance
  logic in_take;       // Request served this cycle
  logic new_run;       // Run bit of the incoming frame
  logic new_rst;       // Reset bit of the incoming frame

  // Next-state logic
  always_comb begin
    state_next = state_reg;
    state_next.out_accept = 1'b0;
    state_next.out_reject = 1'b0;
    state_next.in_valid   = 1'b0;
    state_next.in_reject  = 1'b0;
    state_next.start      = 1'b0;
    state_next.stop       = 1'b0;
    state_next.trip_reset = 1'b0;

    // Only instance 104 in class 4 carries control data
    out_addr_ok = (OUT_FRAME_I.inst == scm_pkg::OUT_INSTANCE)
                && (OUT_FRAME_I.asm_class == scm_pkg::ASM_CLASS);
    // Frames closer than the least interval are dropped, not queued
    out_take = OUT_FRAME_I.valid && out_addr_ok && (state_reg.out_gap >= GAP_LIMIT);
    in_addr_ok = (IN_INST_I == scm_pkg::IN_INSTANCE) && (IN_CLASS_I == scm_pkg::ASM_CLASS);
    in_take = IN_REQ_I && in_addr_ok && (state_reg.in_gap >= GAP_LIMIT);
    new_run = OUT_FRAME_I.data[scm_pkg::RUN_BIT];
    new_rst = OUT_FRAME_I.data[scm_pkg::RESET_BIT];

    state_next.out_gap = gap_step(state_reg.out_gap, out_take);
    state_next.in_gap  = gap_step(state_reg.in_gap, in_take);

    // Control word handling; reserved bits are stored but steer nothing
    if (OUT_FRAME_I.valid) begin
      if (out_take) begin
        state_next.out_accept = 1'b1;
        state_next.cmd_word   = OUT_FRAME_I.data[15:0];
        state_next.bank       = OUT_FRAME_I.data[scm_pkg::BANK_BIT];
        // Duplicate run commands are suppressed, so a start after a local stop needs a stop first
        if (!state_reg.fwd_valid || (state_reg.fwd_run != new_run)) begin
          state_next.fwd_valid = 1'b1;
          state_next.fwd_run   = new_run;
          state_next.start     = new_run;
          state_next.stop      = !new_run;
        end
        // Held reset bit does nothing; only the 0 to 1 step clears a trip
        state_next.trip_reset = new_rst && !state_reg.cmd_word[scm_pkg::RESET_BIT];
      end else begin
        state_next.out_reject = 1'b1;
      end
    end

    // Input assembly, sampled from the starter in the request cycle
    if (IN_REQ_I) begin
      if (in_take) begin
        state_next.in_valid = 1'b1;
        state_next.in_data  = 96'h0;
        state_next.in_data[scm_pkg::IN_STATUS_LSB +: 16] = status_word(STARTER_I);
        state_next.in_data[scm_pkg::IN_AMPS_LSB +: 32]   = STARTER_I.amps;
        state_next.in_data[scm_pkg::IN_FAULT_LSB +: 16]  = STARTER_I.fault;
      end else begin
        state_next.in_reject = 1'b1;
      end
    end

    // Reinitialisation forgets the stored word and the forwarded command
    if (RST_I) begin
      state_next = '0;
      state_next.cmd_word = scm_pkg::CMD_WORD_RST;
      state_next.out_gap  = scm_pkg::GAP_CNT_RST;
      state_next.in_gap   = scm_pkg::GAP_CNT_RST;
    end
  end

  // State register
  always_ff @(posedge CLK_I) begin
    state_reg <= state_next;
  end

  // Outputs come straight from the state register
  assign OUT_ACCEPT_O = state_reg.out_accept;
  assign OUT_REJECT_O = state_reg.out_reject;
  assign IN_VALID_O   = state_reg.in_valid;
  assign IN_REJECT_O  = state_reg.in_reject;
  assign IN_DATA_O    = state_reg.in_data;
  assign CMD_START_O  = state_reg.start;
  assign CMD_STOP_O   = state_reg.stop;
  assign CMD_RESET_O  = state_reg.trip_reset;
  assign BANK_SEL_O   = state_reg.bank;

  // Checks on the block's behaviour
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RST_I);

  // Wrong instance never reaches the starter
  out_inst_only_a: assert property (
    OUT_FRAME_I.valid && (OUT_FRAME_I.inst != scm_pkg::OUT_INSTANCE)
    |=> OUT_REJECT_O && !OUT_ACCEPT_O && !CMD_START_O && !CMD_STOP_O && !CMD_RESET_O)
    else $error("Frame for a foreign instance was accepted");

  // Start only from a taken frame with the run bit set
  start_from_run_a: assert property (
    CMD_START_O |-> $past(out_take) && $past(OUT_FRAME_I.data[scm_pkg::RUN_BIT]) && !CMD_STOP_O)
    else $error("Start issued without run bit");

  // Stop only from a taken frame with the run bit clear
  stop_from_run_a: assert property (
    CMD_STOP_O |-> $past(out_take) && !$past(OUT_FRAME_I.data[scm_pkg::RUN_BIT]))
    else $error("Stop issued without cleared run bit");

  // Trip reset exactly on a rising reset bit
  reset_on_edge_a: assert property (
    out_take |=> CMD_RESET_O == ($past(new_rst) && !$past(state_reg.cmd_word[scm_pkg::RESET_BIT])))
    else $error("Trip reset does not follow the reset bit edge");

  // Bank follows byte 1 bit 5 and holds between frames
  bank_follow_a: assert property (
    out_take |=> (BANK_SEL_O == $past(OUT_FRAME_I.data[scm_pkg::BANK_BIT]))
                 ##1 ($stable(BANK_SEL_O) || OUT_ACCEPT_O))
    else $error("Bank select does not follow control byte 1");

  // Input instance other than 154 is refused
  in_inst_only_a: assert property (
    IN_REQ_I && (IN_INST_I != scm_pkg::IN_INSTANCE) |=> IN_REJECT_O && !IN_VALID_O)
    else $error("Foreign input instance was served");

  // Reserved bytes read zero
  in_reserved_zero_a: assert property (
    IN_VALID_O |-> (IN_DATA_O[scm_pkg::IN_RSVA_LSB +: 16] == 16'h0000)
                && (IN_DATA_O[scm_pkg::IN_RSVB_LSB +: 16] == 16'h0000))
    else $error("Reserved input bytes not zero");

  // Current and fault code copied from the request cycle
  in_payload_a: assert property (
    in_take |=> IN_DATA_O[scm_pkg::IN_AMPS_LSB +: 32] == $past(STARTER_I.amps)
             && IN_DATA_O[scm_pkg::IN_FAULT_LSB +: 16] == $past(STARTER_I.fault))
    else $error("Current or fault code misplaced");

  // Status word bits tie to starter state
  status_bits_a: assert property (
    in_take |=> IN_DATA_O[0] == $past(STARTER_I.ready) && IN_DATA_O[3] == $past(STARTER_I.tripped)
             && IN_DATA_O[11] == $past(STARTER_I.active) && IN_DATA_O[15] == $past(STARTER_I.overtemp)
             && IN_DATA_O[9] == $past(STARTER_I.remote) && IN_DATA_O[8] == $past(STARTER_I.full_volts))
    else $error("Status word bit mismatch");

  // Unused status bits are zero
  status_rsvd_a: assert property (
    IN_VALID_O |-> (IN_DATA_O[15:0] & 16'h7470) == 16'h0000)
    else $error("Reserved status bit set");

  // Repeated run value forwards nothing
  no_duplicate_a: assert property (
    out_take && state_reg.fwd_valid && (new_run == state_reg.fwd_run) |=> !CMD_START_O && !CMD_STOP_O)
    else $error("Duplicate run command forwarded");

  // Accepted frame starts the least interval
  min_gap_a: assert property (
    OUT_ACCEPT_O |-> state_reg.out_gap == 16'h0000 && !out_take)
    else $error("Output frames accepted too close together");

  // Foreign class is refused like a foreign instance
  out_class_only_a: assert property (
    OUT_FRAME_I.valid && (OUT_FRAME_I.asm_class != scm_pkg::ASM_CLASS) |=> OUT_REJECT_O && !OUT_ACCEPT_O)
    else $error("Frame for a foreign class was accepted");

  // Early frames are dropped, never held back for later
  early_reject_a: assert property (
    OUT_FRAME_I.valid && out_addr_ok && (state_reg.out_gap < GAP_LIMIT) |=> OUT_REJECT_O && !OUT_ACCEPT_O)
    else $error("Frame inside the least interval was accepted");

  // A reset bit that stays high must not clear a second trip
  held_reset_a: assert property (
    out_take && new_rst && state_reg.cmd_word[scm_pkg::RESET_BIT] |=> !CMD_RESET_O)
    else $error("Held reset bit cleared a trip again");

  // Accepted word is kept whole, reserved bits included
  word_store_a: assert property (
    out_take |=> state_reg.cmd_word == $past(OUT_FRAME_I.data[15:0]))
    else $error("Accepted control word not stored");

  // Without a new frame the word and the bank stay put
  word_hold_a: assert property (
    !out_take && !RST_I |=> $stable(state_reg.cmd_word) && $stable(BANK_SEL_O))
    else $error("Stored control word changed without a frame");

  // Nothing forwarded yet, so the first frame always reaches the starter
  first_forward_a: assert property (
    out_take && !state_reg.fwd_valid |=> CMD_START_O || CMD_STOP_O)
    else $error("First accepted frame forwarded no command");

  // Reinitialisation forgets everything; checked during reset itself
  reset_clear_a: assert property (disable iff (1'b0)
    RST_I |=> !OUT_ACCEPT_O && !OUT_REJECT_O && !IN_VALID_O && !IN_REJECT_O && !CMD_START_O && !CMD_STOP_O
              && !CMD_RESET_O && !BANK_SEL_O && (IN_DATA_O == 96'h0))
    else $error("Reinitialisation left an output set");

  // Foreign input class is refused
  in_class_only_a: assert property (
    IN_REQ_I && (IN_CLASS_I != scm_pkg::ASM_CLASS) |=> IN_REJECT_O && !IN_VALID_O)
    else $error("Foreign input class was served");

  // Refused or absent requests leave the last assembly in place
  in_hold_a: assert property (
    !in_take && !RST_I |=> $stable(IN_DATA_O))
    else $error("Input assembly changed without a served request");

  // Served request starts the least interval for polls
  in_gap_a: assert property (
    IN_VALID_O |-> state_reg.in_gap == 16'h0000 && !in_take)
    else $error("Input requests served too close together");

  // Current goes out low byte first, at fixed lanes
  amps_order_a: assert property (
    in_take |=> IN_DATA_O[39:32] == $past(STARTER_I.amps[7:0])
             && IN_DATA_O[63:56] == $past(STARTER_I.amps[31:24]))
    else $error("Current bytes out of order");

  // Fault cause sits in bytes 8 and 9
  fault_bytes_a: assert property (
    in_take |=> IN_DATA_O[79:64] == $past(STARTER_I.fault))
    else $error("Fault cause bytes misplaced");

  // Authority and remote bits
  status_net_a: assert property (
    in_take |=> IN_DATA_O[1] == $past(STARTER_I.net_ctrl) && IN_DATA_O[9] == $past(STARTER_I.remote))
    else $error("Authority or remote bit wrong");

  // Full voltage bit
  status_fullv_a: assert property (
    in_take |=> IN_DATA_O[8] == $past(STARTER_I.full_volts))
    else $error("Full voltage bit wrong");

  // Active bit
  status_active_a: assert property (
    in_take |=> IN_DATA_O[11] == $past(STARTER_I.active))
    else $error("Active bit wrong");

  // Overtemperature bit
  status_hot_a: assert property (
    in_take |=> IN_DATA_O[15] == $past(STARTER_I.overtemp))
    else $error("Overtemperature bit wrong");

  // Enabled, trip and warning bits
  status_coast_a: assert property (
    in_take |=> IN_DATA_O[2] == $past(STARTER_I.enabled) && IN_DATA_O[3] == $past(STARTER_I.tripped)
             && IN_DATA_O[7] == $past(STARTER_I.warning))
    else $error("Enabled, trip or warning bit wrong");

  // Main scenarios
  start_seen_c:  cover property (CMD_START_O);
  stop_seen_c:   cover property (CMD_STOP_O);
  reset_seen_c:  cover property (CMD_RESET_O && CMD_START_O);
  reject_seen_c: cover property (OUT_REJECT_O);
  poll_seen_c:   cover property (IN_VALID_O);

endmodule

// File: src/scm_pkg.sv
// Package with constants and carrier types of the starter cyclic command and status map
package scm_pkg;

  // Assembly addressing
  localparam logic [7:0] ASM_CLASS     = 8'h04;  // Assembly class for both directions
  localparam logic [7:0] OUT_INSTANCE  = 8'h68;  // Output instance 104
  localparam logic [7:0] IN_INSTANCE   = 8'h9A;  // Input instance 154

  // Control word field positions (byte 0 in bits 7:0, byte 1 in bits 15:8)
  localparam int RUN_BIT   = 6;                  // Byte 0 bit 6
  localparam int RESET_BIT = 7;                  // Byte 0 bit 7
  localparam int BANK_BIT  = 13;                 // Byte 1 bit 5

  // Status word field positions
  localparam int ST_READY_POS   = 0;
  localparam int ST_NET_POS     = 1;
  localparam int ST_ENABLE_POS  = 2;
  localparam int ST_TRIP_POS    = 3;
  localparam int ST_WARN_POS    = 7;
  localparam int ST_FULLV_POS   = 8;
  localparam int ST_REMOTE_POS  = 9;
  localparam int ST_ON_POS      = 11;
  localparam int ST_HOT_POS     = 15;

  // Input assembly byte lanes (little endian, byte n at bits 8n+7:8n)
  localparam int IN_STATUS_LSB  = 0;
  localparam int IN_RSVA_LSB    = 16;
  localparam int IN_AMPS_LSB    = 32;
  localparam int IN_FAULT_LSB   = 64;
  localparam int IN_RSVB_LSB    = 80;

  // Reset values
  localparam logic [15:0] CMD_WORD_RST = 16'h0000;  // Stored control word after reset
  localparam logic [15:0] GAP_CNT_RST  = 16'hFFFF;  // Gap counter starts satisfied

  // Least cyclic interval
  localparam int CLK_PERIOD_NS = 20;                // 50 MHz system clock
  localparam int MIN_CYCLE_MS  = 1;                 // Least exchange interval in ms
  localparam int MIN_GAP_CYC   = (MIN_CYCLE_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Cyclic output frame from the scanner
  typedef struct packed {
    logic        valid;     // One-cycle strobe
    logic [7:0]  asm_class; // Assembly class
    logic [7:0]  inst;      // Assembly instance
    logic [31:0] data;      // Bytes 0..3, byte 0 lowest
  } scm_out_frame_t;

  // Starter state as seen by the block
  typedef struct packed {
    logic        ready;      // Start or stop acceptable
    logic        net_ctrl;   // Network holds authority
    logic        enabled;    // Motor enabled, not coasting
    logic        tripped;    // Starter tripped
    logic        warning;    // Warning present
    logic        full_volts; // Full voltage at motor
    logic        remote;     // Remote control
    logic        active;     // Starting, running, stopping, jogging
    logic        overtemp;   // Motor above normal temperature
    logic [31:0] amps;       // Current in 0.01 A
    logic [15:0] fault;      // Fault cause code
  } scm_starter_t;

endpackage

// File: test/scm_scanner_model.sv
// Scanner controller model that issues cyclic frames and status polls
`timescale 1ns/100ps

module scm_scanner_model #(
  parameter int GAP = 8                      // Least cycles between exchanges
) (
  input  wire logic               clk_i,     // System clock
  output scm_pkg::scm_out_frame_t frame_o,   // Cyclic output frame
  output logic                    req_o,     // Poll strobe
  output logic [7:0]              cls_o,     // Poll class
  output logic [7:0]              inst_o,    // Poll instance
  input  wire logic               acc_i,     // Frame taken
  input  wire logic               rej_i,     // Frame refused
  input  wire logic               inv_i,     // Poll served
  input  wire logic               inrej_i    // Poll refused
);
  // Lines start idle; no request before reset ends
  initial begin
    frame_o = '0;
    req_o   = 1'b0;
    cls_o   = 8'h00;
    inst_o  = 8'h00;
  end

  // One frame, held for one edge, then released with inverted lines so nothing stale looks valid
  // The bank bit is used freely: this starter has no input that also picks the bank
  task automatic send(input logic [7:0] c, input logic [7:0] i, input logic [15:0] w,
                      input bit early, output logic a, output logic r);
    if (!early) begin
      repeat (GAP) @(posedge clk_i);
    end
    @(posedge clk_i);
    frame_o <= {1'b1, c, i, 16'h0000, w};
    @(posedge clk_i);
    frame_o <= {1'b0, ~c, ~i, 16'hFFFF, ~w};
    #1;
    a = acc_i;
    r = rej_i;
  endtask

  // One status poll, same spacing and release habits as frames
  task automatic poll(input logic [7:0] c, input logic [7:0] i, input bit early,
                      output logic v, output logic r);
    if (!early) begin
      repeat (GAP) @(posedge clk_i);
    end
    @(posedge clk_i);
    req_o  <= 1'b1;
    cls_o  <= c;
    inst_o <= i;
    @(posedge clk_i);
    req_o  <= 1'b0;
    cls_o  <= ~c;
    inst_o <= ~i;
    #1;
    v = inv_i;
    r = inrej_i;
  endtask
endmodule

// File: test/tb.sv
// Self-checking testbench for the cyclic command and status map
`timescale 1ns/100ps

module tb;
  localparam int GAP = 8;                 // Shortened exchange interval
  logic                    clk;           // System clock
  logic                    rst;           // Synchronous reset
  scm_pkg::scm_out_frame_t frame;         // Frame from scanner model
  logic                    req;           // Poll strobe
  logic [7:0]              cls;           // Poll class
  logic [7:0]              ins;           // Poll instance
  logic                    acc, rej;      // Frame answers
  logic                    inv, irej;     // Poll answers
  logic                    st, sp, rs;    // Command pulses
  logic                    bank;          // Bank select
  logic [95:0]             idata;         // Input assembly
  scm_pkg::scm_starter_t   starter;       // Starter state
  int                      mismatches = 0;
  int                      samples_checked = 0;
  logic [15:0]             rnd = 16'h8EDF; // Random state, 36575
  logic [15:0]             last_word = '0; // Bench model: last accepted word
  int                      last_cmd = 0;   // Bench model: 0 none, 1 start, 2 stop
  logic [95:0]             exp_data = '0;  // Bench model: last served assembly

  scm_map #(.GAP_CYCLES(GAP)) dut (
    .CLK_I(clk), .RST_I(rst), .OUT_FRAME_I(frame), .OUT_ACCEPT_O(acc), .OUT_REJECT_O(rej),
    .IN_REQ_I(req), .IN_CLASS_I(cls), .IN_INST_I(ins), .IN_VALID_O(inv), .IN_REJECT_O(irej),
    .IN_DATA_O(idata), .STARTER_I(starter), .CMD_START_O(st), .CMD_STOP_O(sp),
    .CMD_RESET_O(rs), .BANK_SEL_O(bank));

  scm_scanner_model #(.GAP(GAP)) scn (
    .clk_i(clk), .frame_o(frame), .req_o(req), .cls_o(cls), .inst_o(ins),
    .acc_i(acc), .rej_i(rej), .inv_i(inv), .inrej_i(irej));

  // Free-running clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Sixteen-bit shift register for repeatable random values
  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction

  // Expected input assembly, byte 0 lowest
  function automatic logic [95:0] build(input scm_pkg::scm_starter_t s);
    logic [15:0] w;
    w = {s.overtemp, 3'b000, s.active, 1'b0, s.remote, s.full_volts, s.warning,
         3'b000, s.tripped, s.enabled, s.net_ctrl, s.ready};
    return {16'h0000, s.fault, s.amps, 16'h0000, w};
  endfunction

  // Single comparison point
  task automatic check(input string n, input logic [95:0] seen, input logic [95:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", n, exp, seen);
    end
  endtask

  // One frame; the bench model predicts answer and commands
  task automatic frame_step(input logic [7:0] c, input logic [7:0] i, input logic [15:0] w, input bit early);
    logic a, r, e_st, e_sp, e_rs;
    bit   ok;
    ok   = (c == 8'h04) && (i == 8'd104) && !early;
    e_st = 1'b0;
    e_sp = 1'b0;
    e_rs = 1'b0;
    scn.send(c, i, w, early, a, r);
    if (ok) begin
      e_st = w[6] && (last_cmd != 1);
      e_sp = !w[6] && (last_cmd != 2);
      e_rs = w[7] && !last_word[7];
      last_cmd = w[6] ? 1 : 2;
      last_word = w;
    end
    check("accept", a, ok);
    check("reject", r, !ok);
    check("start", st, e_st);
    check("stop", sp, e_sp);
    check("trip reset", rs, e_rs);
    check("bank", bank, last_word[13]);
  endtask

  // One poll; data must follow the starter or stay put when refused
  task automatic poll_step(input logic [7:0] c, input logic [7:0] i, input bit early);
    logic v, r;
    bit   ok;
    ok = (c == 8'h04) && (i == 8'd154) && !early;
    scn.poll(c, i, early, v, r);
    if (ok) begin
      exp_data = build(starter);
    end
    check("in valid", v, ok);
    check("in reject", r, !ok);
    check("in data", idata, exp_data);
  endtask

  // Verdict and end of run
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Watchdog well beyond the expected few hundred cycles
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    report_and_stop;
  end

  // Main sequence
  initial begin
    logic [15:0] words [9];
    words = '{16'h0040, 16'h00C0, 16'h00C0, 16'h0040, 16'h0080, 16'h2000, 16'h0000, 16'h20C0, 16'h0040};
    rst = 1'b1;
    starter = '0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    check("idle outputs", {acc, rej, inv, irej, st, sp, rs, bank}, 8'h00);
    check("idle data", idata, '0);
    // Fixed command table: repeats, reset edges, bank changes
    foreach (words[k]) frame_step(8'h04, 8'd104, words[k], 1'b0);
    $display("test commands done");
    // Wrong class, wrong instance, then a too-early frame
    frame_step(8'h05, 8'd104, 16'h0080, 1'b0);
    frame_step(8'h04, 8'd105, 16'h2080, 1'b0);
    frame_step(8'h04, 8'd104, 16'h0000, 1'b0);
    frame_step(8'h04, 8'd104, 16'h20C0, 1'b1);
    $display("test refusals done");
    // Random words within the defined bits
    for (int k = 0; k < 8; k++) begin
      rnd = lfsr(rnd);
      frame_step(8'h04, 8'd104, rnd & 16'h20C0, 1'b0);
    end
    $display("test random commands done");
    // Status polls with random starter state
    for (int k = 0; k < 6; k++) begin
      rnd = lfsr(rnd);
      @(posedge clk);
      starter <= {rnd[8:0], rnd, ~rnd, lfsr(rnd)};
      poll_step(8'h04, 8'd154, 1'b0);
    end
    @(posedge clk);
    starter <= ~starter;
    poll_step(8'h04, 8'd153, 1'b0);
    poll_step(8'h03, 8'd154, 1'b0);
    poll_step(8'h04, 8'd154, 1'b0);
    poll_step(8'h04, 8'd154, 1'b1);
    $display("test status done");
    // Mid-run reinitialisation must forget the stored word and the last command
    frame_step(8'h04, 8'd104, 16'h00C0, 1'b0);
    @(posedge clk);
    rst <= 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    check("reinit outputs", {acc, rej, inv, irej, st, sp, rs, bank}, 8'h00);
    check("reinit data", idata, '0);
    last_cmd  = 0;
    last_word = '0;
    exp_data  = '0;
    frame_step(8'h04, 8'd104, 16'h00C0, 1'b0);
    $display("test reinit done");
    report_and_stop;
  end
endmodule
